// *** design/swsig_pkg.sv ***
// Package with timing constants, commands and carrier types for the line controller
// Function
// - Overdrive match command 69h is followed by 64 ROM bits sent at overdrive speed.
// - Controller avoids overdrive reset lows between 80us and 480us.
// - Controller makes every falling edge except the presence pulse.
// - Only reset/presence, write-zero, write-one and read slots exist on the line.
// - Controller samples presence at presence_sample_point after releasing reset.
// - Reset high window covers presence wait, presence low and recovery.
// - Reset high window is always 480us standard, 48us overdrive; the ext request bit is stored but never stretches it.
// - Each slot carries one bit; write slots out, read slots in.
// - Write-one releases before write_one_low max; write-zero holds past minimum.
// - After each slot the line stays high for the recovery time.
// - Controller samples read data inside window, late but before its maximum.
// - After sampling, controller waits out the full slot time.
// - Bus idles high; long lows reset devices, so suspended traffic idles high.
package swsig_pkg;
  localparam int unsigned CLK_MHZ = 125;

  // Times in nanoseconds per speed
  localparam int unsigned STD_RST_LOW_NS  = 600000;
  localparam int unsigned STD_RST_HIGH_NS = 480000;
  localparam int unsigned STD_PRES_SMP_NS = 70000;
  localparam int unsigned STD_W0_LOW_NS   = 65000;
  localparam int unsigned STD_W1_LOW_NS   = 8000;
  localparam int unsigned STD_RD_LOW_NS   = 5000;
  localparam int unsigned STD_RD_SMP_NS   = 13000;
  localparam int unsigned STD_SLOT_NS     = 75000;
  localparam int unsigned STD_REC_NS      = 5000;
  localparam int unsigned OD_RST_LOW_NS   = 70000;
  localparam int unsigned OD_RST_HIGH_NS  = 48000;
  localparam int unsigned OD_PRES_SMP_NS  = 10000;
  localparam int unsigned OD_W0_LOW_NS    = 10000;
  localparam int unsigned OD_W1_LOW_NS    = 1000;
  localparam int unsigned OD_RD_LOW_NS    = 1000;
  localparam int unsigned OD_RD_SMP_NS    = 2000;
  localparam int unsigned OD_SLOT_NS      = 12000;
  localparam int unsigned OD_REC_NS       = 5000;
  localparam int unsigned LONG_RST_MIN_NS = 480000;
  localparam int unsigned OD_RST_MAX_NS   = 80000;

  localparam int unsigned CW = 17;
  typedef logic [CW-1:0] swsig_cnt_t;

  // Least times round up
  function automatic swsig_cnt_t swsig_cyc(input int unsigned ns);
    int unsigned c;
    c = (ns * CLK_MHZ + 999) / 1000;
    if (c < 1) c = 1;
    return swsig_cnt_t'(c);
  endfunction

  // Command codes
  localparam logic [7:0] CMD_OD_MATCH = 8'h69;
  localparam logic [7:0] CMD_OD_SKIP  = 8'h3c;
  localparam logic [6:0] ROM_BITS     = 7'h40;

  // Register offsets of the controller's own port
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_TXBIT  = 4'h2;
  localparam logic [3:0] REG_RXDATA = 4'h3;
  localparam logic [3:0] REG_ROMLO  = 4'h4;
  localparam logic [3:0] REG_ROMHI  = 4'h5;

  // Operation codes written to CTRL[2:0]
  typedef enum logic [2:0] {
    OP_NONE, OP_RESET, OP_WRITE_BIT, OP_READ_BIT, OP_OD_MATCH, OP_OD_SKIP
  } swsig_op_t;

  // Software register port
  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } swsig_bus_t;

  // Line pin pair
  typedef struct packed {
    logic out;
    logic oe;
  } swsig_pin_t;

  // Request to the slot engine
  typedef struct packed {
    logic go;
    logic is_reset;
    logic bitval;
    logic od;
    logic ext_high;
  } swsig_slot_req_t;
endpackage

// *** design/swsig_sync.sv ***
// Two-flop synchroniser for the line input
`timescale 1ns/100ps
`default_nettype none
module swsig_sync
  import swsig_pkg::*;
(
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rstn_i,
  // Async level in, synced out
  input  wire logic d_i,
  output var  logic q_o
);
  typedef struct packed {
    logic s1;
    logic s2;
  } swsig_sync_st_t;
  swsig_sync_st_t st_r, st_nxt;

  // Idle line is high, so reset to high
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = d_i;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      st_r <= 2'h3;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q_o = st_r.s2;
endmodule
`default_nettype wire

// *** design/swsig_slot.sv ***
// Slot engine: one reset/presence sequence or one bit slot on the line
`timescale 1ns/100ps
`default_nettype none
module swsig_slot
  import swsig_pkg::*;
(
  // Clock and reset
  input  wire logic            clk_i,
  input  wire logic            rstn_i,
  // Request and result
  input  wire swsig_slot_req_t req_i,
  input  wire logic            line_i,
  output var  logic            busy_o,
  output var  logic            done_o,
  output var  logic            sample_o,
  // Pin drive
  output var  swsig_pin_t      pin_o
);
  typedef enum logic [1:0] {S_IDLE, S_LOW, S_HIGH} swsig_sst_t;
  typedef struct packed {
    swsig_sst_t st;
    swsig_cnt_t cnt;
    logic       is_reset;
    logic       bitval;
    logic       od;
    logic       ext;
    logic       sample;
    logic       done;
    logic       drive;
  } swsig_slot_st_t;
  swsig_slot_st_t s_r, s_nxt;

  // Low phase length per waveform kind and speed
  function automatic swsig_cnt_t low_len(input logic rst, input logic bv, input logic od);
    if (rst) return od ? swsig_cyc(OD_RST_LOW_NS) : swsig_cyc(STD_RST_LOW_NS);
    if (bv)  return od ? swsig_cyc(OD_RD_LOW_NS)  : swsig_cyc(STD_RD_LOW_NS);
    return od ? swsig_cyc(OD_W0_LOW_NS) : swsig_cyc(STD_W0_LOW_NS);
  endfunction

  always_comb begin
    s_nxt      = s_r;
    s_nxt.done = 1'b0;
    case (s_r.st)
      S_IDLE: begin
        if (req_i.go) begin
          // Controller makes the falling edge
          s_nxt.st       = S_LOW;
          s_nxt.is_reset = req_i.is_reset;
          s_nxt.bitval   = req_i.bitval;
          s_nxt.od       = req_i.od;
          s_nxt.ext      = req_i.ext_high;
          s_nxt.drive    = 1'b1;
          s_nxt.cnt      = low_len(req_i.is_reset, req_i.bitval, req_i.od);
        end
      end
      S_LOW: begin
        if (s_r.cnt <= 1) begin
          s_nxt.drive = 1'b0;
          s_nxt.st    = S_HIGH;
          if (s_r.is_reset) begin
            s_nxt.cnt = s_r.od ? swsig_cyc(OD_RST_HIGH_NS) : swsig_cyc(STD_RST_HIGH_NS);
          end else begin
            s_nxt.cnt = (s_r.od ? swsig_cyc(OD_SLOT_NS) : swsig_cyc(STD_SLOT_NS))
                      - low_len(1'b0, s_r.bitval, s_r.od)
                      + (s_r.od ? swsig_cyc(OD_REC_NS) : swsig_cyc(STD_REC_NS));
          end
        end else begin
          s_nxt.cnt = s_r.cnt - 1'b1;
        end
      end
      S_HIGH: begin
        s_nxt.cnt = s_r.cnt - 1'b1;
        // Sample points counted from line release
        if (s_r.is_reset && s_r.cnt == (s_r.od ? swsig_cyc(OD_RST_HIGH_NS)
            - swsig_cyc(OD_PRES_SMP_NS) : swsig_cyc(STD_RST_HIGH_NS)
            - swsig_cyc(STD_PRES_SMP_NS))) begin
          s_nxt.sample = ~line_i;
        end
        if (!s_r.is_reset && s_r.cnt == (s_r.od ? swsig_cyc(OD_SLOT_NS) - swsig_cyc(OD_RD_SMP_NS)
            : swsig_cyc(STD_SLOT_NS) - swsig_cyc(STD_RD_SMP_NS))
            + (s_r.od ? swsig_cyc(OD_REC_NS) : swsig_cyc(STD_REC_NS))) begin
          s_nxt.sample = line_i;
        end
        if (s_r.cnt <= 1) begin
          s_nxt.st   = S_IDLE;
          s_nxt.done = 1'b1;
        end
      end
      default: s_nxt.st = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign busy_o    = (s_r.st != S_IDLE);
  assign done_o    = s_r.done;
  assign sample_o  = s_r.sample;
  assign pin_o.out = 1'b0;
  assign pin_o.oe  = s_r.drive;

  // Line never held low longer than the reset low time
  int unsigned low_run;
  always_ff @(posedge clk_i) begin
    if (!rstn_i || !s_r.drive) low_run <= 0;
    else low_run <= low_run + 1;
  end
  low_bounded_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    low_run <= swsig_cyc(STD_RST_LOW_NS) + 1) else $error("line held low too long");
  drive_start_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (s_r.st == S_IDLE && req_i.go) |=> s_r.drive) else $error("no falling edge on go");
  od_reset_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (s_r.st == S_LOW && s_r.is_reset && s_r.od) |-> s_r.cnt <= swsig_cyc(OD_RST_MAX_NS))
    else $error("overdrive reset too long");
  done_pulse_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    done_o |=> !done_o) else $error("done not a pulse");
endmodule
`default_nettype wire

// *** design/swsig_ctrl.sv ***
// Line controller: register port, speed state and overdrive command sequencing
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module swsig_ctrl
  import swsig_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // Software port
  input  wire logic [3:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  // Line pin, open drain
  input  wire logic        line_i,
  output logic             line_o,
  output logic             line_oe_o
);
  typedef enum logic [2:0] {C_IDLE, C_SLOT, C_CMD, C_ROM} swsig_cst_t;
  typedef struct packed {
    swsig_cst_t  st;
    logic        od;
    logic        ext;
    logic        presence;
    logic        rx;
    logic        txbit;
    logic [7:0]  cmd;
    logic [63:0] rom;
    logic [6:0]  idx;
    logic        go;
    logic        is_reset;
    logic        bitval;
    logic        wait_done;
    logic        done_flag;
    logic        od_after;
    logic [31:0] rdata;
  } swsig_ctrl_st_t;
  swsig_ctrl_st_t c_r, c_nxt;

  logic            line_s;
  logic            eng_busy;
  logic            eng_done;
  logic            eng_smp;
  swsig_pin_t      pin;
  swsig_slot_req_t req;

  // Pin input passes two flops
  swsig_sync u_sync (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .d_i    (line_i),
    .q_o    (line_s)
  );

  assign req.go       = c_r.go;
  assign req.is_reset = c_r.is_reset;
  assign req.bitval   = c_r.bitval;
  assign req.od       = c_r.od;
  assign req.ext_high = c_r.ext;

  swsig_slot u_slot (
    .clk_i    (clk_i),
    .rstn_i   (rstn_i),
    .req_i    (req),
    .line_i   (line_s),
    .busy_o   (eng_busy),
    .done_o   (eng_done),
    .sample_o (eng_smp),
    .pin_o    (pin)
  );

  // Register decode, sequencing and speed tracking
  always_comb begin
    c_nxt       = c_r;
    c_nxt.go    = 1'b0;
    c_nxt.rdata = 32'h0;
    if (rd_i) begin
      case (addr_i)
        REG_CTRL:   c_nxt.rdata = {30'h0, c_r.ext, c_r.od};
        REG_STATUS: c_nxt.rdata = {28'h0, c_r.done_flag, c_r.presence, c_r.od,
                                   c_r.st != C_IDLE};
        REG_TXBIT:  c_nxt.rdata = {31'h0, c_r.txbit};
        REG_RXDATA: c_nxt.rdata = {31'h0, c_r.rx};
        REG_ROMLO:  c_nxt.rdata = c_r.rom[31:0];
        REG_ROMHI:  c_nxt.rdata = c_r.rom[63:32];
        default:    c_nxt.rdata = 32'h0;
      endcase
    end
    if (wr_i) begin
      case (addr_i)
        REG_TXBIT: c_nxt.txbit = wdata_i[0];
        REG_ROMLO: c_nxt.rom[31:0] = wdata_i;
        REG_ROMHI: c_nxt.rom[63:32] = wdata_i;
        default: ;
      endcase
    end
    if (wr_i && addr_i == REG_CTRL && c_r.st == C_IDLE) begin
      c_nxt.ext       = wdata_i[4];
      c_nxt.done_flag = 1'b0;
      case (swsig_op_t'(wdata_i[2:0]))
        OP_RESET: begin
          // Long reset unless kept at overdrive by wdata bit 3
          c_nxt.od = c_r.od & wdata_i[3];
          c_nxt.is_reset = 1'b1;
          c_nxt.go = 1'b1;
          c_nxt.st = C_SLOT;
          c_nxt.od_after = c_r.od & wdata_i[3];
        end
        OP_WRITE_BIT, OP_READ_BIT: begin
          c_nxt.is_reset = 1'b0;
          c_nxt.bitval = (swsig_op_t'(wdata_i[2:0]) == OP_READ_BIT) | c_r.txbit;
          c_nxt.go = 1'b1;
          c_nxt.st = C_SLOT;
          c_nxt.od_after = c_r.od;
        end
        OP_OD_MATCH, OP_OD_SKIP: begin
          c_nxt.cmd = (swsig_op_t'(wdata_i[2:0]) == OP_OD_MATCH) ? CMD_OD_MATCH
                      : CMD_OD_SKIP;
          c_nxt.idx = 7'h0;
          c_nxt.st  = C_CMD;
        end
        default: ;
      endcase
    end
    // Command byte LSB first, at current speed
    if (c_r.st == C_CMD && !eng_busy && !c_r.go) begin
      if (c_r.idx == 7'h8) begin
        c_nxt.od  = 1'b1;
        c_nxt.idx = 7'h0;
        c_nxt.st  = (c_r.cmd == CMD_OD_MATCH) ? C_ROM : C_IDLE;
        c_nxt.done_flag = (c_r.cmd != CMD_OD_MATCH);
      end else begin
        c_nxt.is_reset = 1'b0;
        c_nxt.bitval   = c_r.cmd[c_r.idx[2:0]];
        c_nxt.go       = 1'b1;
        c_nxt.idx      = c_r.idx + 7'h1;
      end
    end
    // ROM code at overdrive speed, LSB first
    if (c_r.st == C_ROM && !eng_busy && !c_r.go) begin
      if (c_r.idx == ROM_BITS) begin
        c_nxt.st = C_IDLE;
        c_nxt.done_flag = 1'b1;
      end else begin
        c_nxt.is_reset = 1'b0;
        c_nxt.bitval   = c_r.rom[c_r.idx[5:0]];
        c_nxt.go       = 1'b1;
        c_nxt.idx      = c_r.idx + 7'h1;
      end
    end
    if (c_r.st == C_SLOT && eng_done) begin
      c_nxt.st = C_IDLE;
      c_nxt.done_flag = 1'b1;
      c_nxt.od = c_r.od_after;
      if (c_r.is_reset) c_nxt.presence = eng_smp;
      else c_nxt.rx = eng_smp;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      c_r <= '0;
    end else begin
      c_r <= c_nxt;
    end
  end

  // Bus port pieces
  assign rdata_o   = c_r.rdata;
  assign line_o    = pin.out;
  assign line_oe_o = pin.oe;

  od_after_skip_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (c_r.st == C_CMD && c_r.idx == 7'h8 && !eng_busy && !c_r.go) |=> c_r.od)
    else $error("overdrive not set after command");
  rom_speed_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (c_r.st == C_ROM) |-> c_r.od) else $error("ROM bits not at overdrive");
  long_reset_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (wr_i && addr_i == REG_CTRL && c_r.st == C_IDLE && wdata_i[2:0] == 3'h1 && !wdata_i[3])
    |=> !c_r.od) else $error("long reset kept overdrive");
  short_reset_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (wr_i && addr_i == REG_CTRL && c_r.st == C_IDLE && wdata_i[2:0] == 3'h1
     && wdata_i[3] && c_r.od) |=> c_r.od) else $error("short reset lost overdrive");
endmodule
`default_nettype wire

// *** testbench/swsig_dev_model.sv ***
// Behavioural model of one overdrive-capable peripheral on the line
`timescale 1ns/100ps
`default_nettype none
module swsig_dev_model #(
  parameter logic [63:0] ROM_CODE = 64'h4d21_9ac3_07e5_b816  // Arbitrary code
) (
  // Clock
  input  wire logic clk_i,
  // Line level and own pulldown
  input  wire logic line_i,
  output var  logic pull_o,
  // Speed and selection state for the bench
  output var  logic od_o,
  output var  logic sel_o
);
  // Durations in 8 ns cycles, picked by od_o
  localparam int LONG_RST = 60000;  // 480 us low
  int         low_len = 0;
  int         hi_len  = 0;
  int         tcnt    = 0;
  int         pcnt    = 0;
  int         nbit    = 0;
  logic       prev    = 1'b1;
  logic       in_slot = 1'b0;
  logic       hi_ok   = 1'b0;
  logic       was_od  = 1'b0;
  logic       match   = 1'b0;
  logic       b       = 1'b1;
  logic [1:0] st      = 2'h3;  // 0 command, 1 code, 2 selected, 3 silent
  logic [7:0] cmd     = 8'h00;

  // Outputs start released at standard speed
  initial begin
    pull_o = 1'b0;
    od_o   = 1'b0;
    sel_o  = 1'b0;
  end

  // Pulls low only in its presence or in a slot the controller began
  always @(posedge clk_i) begin
    int   smp;
    int   hold;
    logic mt;
    smp     = od_o ? 375 : 3750;
    hold    = od_o ? 375 : 1875;
    prev    <= line_i;
    low_len <= line_i ? 0 : low_len + 1;
    hi_len  <= line_i ? hi_len + 1 : 0;
    hi_ok   <= line_i ? (hi_len >= 50) : hi_ok;  // Rise holdoff
    if (pcnt != 0) begin
      // Own presence pulse; line edges ignored meanwhile
      pcnt <= pcnt + 1;
      if (pcnt == (od_o ? 250 : 1875))
        pull_o <= 1'b1;
      if (pcnt == (od_o ? 1750 : 16875)) begin
        pull_o <= 1'b0;
        pcnt   <= 0;
      end
    end else if (line_i && !prev && low_len >= (od_o ? 5000 : LONG_RST)) begin
      // Reset seen at the rise; only a long one drops overdrive
      if (low_len >= LONG_RST)
        od_o <= 1'b0;
      pcnt    <= 1;
      in_slot <= 1'b0;
      st      <= 2'h0;
      nbit    <= 0;
      sel_o   <= 1'b0;
      pull_o  <= 1'b0;
    end else if (!in_slot && !line_i && hi_ok && low_len == (od_o ? 0 : 1)) begin
      // Fall, filtered at standard speed only, starts the timer
      in_slot <= 1'b1;
      tcnt    <= 0;
      pull_o  <= (st == 2'h2);  // Selected answers 0
    end else if (in_slot) begin
      tcnt <= tcnt + 1;
      if (tcnt == smp)
        b <= line_i;
      if (tcnt == hold)
        pull_o <= 1'b0;
      if (tcnt > smp && tcnt > hold && line_i) begin
        // One bit a slot, taken once the line is back high
        in_slot <= 1'b0;
        nbit    <= nbit + 1;
        if (st == 2'h0) begin
          cmd = {b, cmd[7:1]};  // Least significant bit first
          if (nbit == 7) begin
            nbit   <= 0;
            was_od <= od_o;
            match  <= 1'b1;
            st     <= 2'h3;
            if (cmd == 8'h3c) begin
              od_o  <= 1'b1;
              st    <= 2'h2;
              sel_o <= 1'b1;
            end else if (cmd == 8'h69) begin
              od_o <= 1'b1;  // Code follows at overdrive
              st   <= 2'h1;
            end
          end
        end else if (st == 2'h1) begin
          mt    = match && (b == ROM_CODE[nbit]);
          match <= mt;
          if (nbit == 63) begin
            st    <= mt ? 2'h2 : 2'h3;
            sel_o <= mt;
            od_o  <= mt | was_od;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** testbench/testbench.sv ***
// Self-checking bench for the line controller against a peripheral model
`timescale 1ns/100ps
`default_nettype none
module testbench
  import swsig_pkg::*;
;
  // Row of the ordinary-case table
  typedef struct {
    logic [31:0] ctl;
    logic        tx;
    logic [31:0] mask;
    logic [31:0] st;
    int          len;
  } swsig_tb_row_t;
  localparam logic [63:0] ROM = 64'h4d21_9ac3_07e5_b816;  // Arbitrary code
  logic        clk_i   = 1'b0;
  logic        rstn_i  = 1'b0;
  logic [3:0]  addr_i  = 4'h0;
  logic [31:0] wdata_i = 32'h0;
  logic        wr_i    = 1'b0;
  logic        rd_i    = 1'b0;
  logic [31:0] rdata_o;
  logic        line_o;
  logic        line_oe_o;
  logic        dev_pull;
  logic        dev_od;
  logic        dev_sel;
  logic [31:0] d;
  int          errors  = 0;
  int          checks  = 0;
  int          run     = 0;
  int          oe_len  = 0;
  // Overdrive-speed cases, run after the skip command selected the model
  swsig_tb_row_t rows [4] = '{
    '{32'(OP_WRITE_BIT), 1'b1, 32'hb, 32'ha, OD_W1_LOW_NS / 8},
    '{32'(OP_WRITE_BIT), 1'b0, 32'hb, 32'ha, OD_W0_LOW_NS / 8},
    '{32'(OP_READ_BIT), 1'b1, 32'hb, 32'ha, OD_RD_LOW_NS / 8},
    '{32'h8 | 32'(OP_RESET), 1'b1, 32'hf, 32'he, OD_RST_LOW_NS / 8}
  };
  // Open-drain wire with pull-up
  wire logic   line_w = ~(line_oe_o | dev_pull);

  swsig_ctrl swsig_ctrl_inst (
    .clk_i     (clk_i),
    .rstn_i    (rstn_i),
    .addr_i    (addr_i),
    .wdata_i   (wdata_i),
    .wr_i      (wr_i),
    .rd_i      (rd_i),
    .rdata_o   (rdata_o),
    .line_i    (line_w),
    .line_o    (line_o),
    .line_oe_o (line_oe_o)
  );

  swsig_dev_model #(.ROM_CODE(ROM)) swsig_dev_model_inst (
    .clk_i  (clk_i),
    .line_i (line_w),
    .pull_o (dev_pull),
    .od_o   (dev_od),
    .sel_o  (dev_sel)
  );

  // 125 MHz clock
  initial begin
    forever #4 clk_i = ~clk_i;
  end

  // Length of the last low pulse the controller drove
  always @(posedge clk_i) begin
    if (line_oe_o)
      run <= run + 1;
    else if (run != 0) begin
      oe_len <= run;
      run    <= 0;
    end
  end

  task automatic stop_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Pulse lengths allow two cycles of pipeline slack
  task automatic chk_len(input int got, input int exp);
    checks++;
    if (got < exp - 2 || got > exp + 2) begin
      errors++;
      $display("BAD %0t pulse %0d cycles expected %0d", $time, got, exp);
    end
  endtask

  task automatic bus_wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= v;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic bus_rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1 v = rdata_o;
  endtask

  // Bounded poll of the busy flag
  task automatic wait_idle();
    repeat (4) @(posedge clk_i);
    d = 32'h1;
    for (int n = 0; n < 150000 && d[0] !== 1'b0; n++)
      bus_rd(REG_STATUS, d);
    if (d[0] !== 1'b0) begin
      errors++;
      $display("BAD %0t busy never cleared", $time);
      stop_test();
    end
  endtask

  task automatic run_op(input logic [31:0] ctl);
    bus_wr(REG_CTRL, ctl);
    wait_idle();
  endtask

  // Main sequence
  initial begin
    repeat (4) @(posedge clk_i);
    // Release on the edge; outputs still show the reset state just after it
    rstn_i <= 1'b1;
    #1 chk({30'h0, line_o, line_oe_o}, 32'h0);
    chk(rdata_o, 32'h0);
    bus_rd(REG_STATUS, d);
    chk(d, 32'h0);
    bus_rd(REG_CTRL, d);
    chk(d, 32'h0);
    // Standard reset, presence seen
    run_op(32'(OP_RESET));
    chk_len(oe_len, STD_RST_LOW_NS / 8);
    bus_rd(REG_STATUS, d);
    chk(d & 32'hf, 32'hc);
    @(posedge clk_i);
    #1 chk(rdata_o, 32'h0);
    // Skip command at standard speed; last bit of 3Ch is a zero
    run_op(32'(OP_OD_SKIP));
    chk_len(oe_len, STD_W0_LOW_NS / 8);
    chk({30'h0, dev_sel, dev_od}, 32'h3);
    foreach (rows[i]) begin
      bus_wr(REG_TXBIT, {31'h0, rows[i].tx});
      run_op(rows[i].ctl);
      chk_len(oe_len, rows[i].len);
      bus_rd(REG_STATUS, d);
      chk(d & rows[i].mask, rows[i].st);
      if (rows[i].ctl == 32'(OP_READ_BIT)) begin
        bus_rd(REG_RXDATA, d);
        chk(d & 32'h1, 32'h0);
      end
    end
    // Match with the right code, then with one bit wrong
    for (int k = 0; k < 2; k++) begin
      bus_wr(REG_ROMLO, ROM[31:0] ^ 32'(k));
      bus_wr(REG_ROMHI, ROM[63:32]);
      run_op(32'(OP_OD_MATCH));
      chk({30'h0, dev_sel, dev_od}, k ? 32'h1 : 32'h3);
      run_op(32'(OP_READ_BIT));
      bus_rd(REG_RXDATA, d);
      chk(d & 32'h1, 32'(k));
      run_op(32'h8 | 32'(OP_RESET));
    end
    // Long reset; an op written while busy must be dropped
    // Extended high window asked for as well
    bus_wr(REG_CTRL, 32'h10 | 32'(OP_RESET));
    repeat (4) @(posedge clk_i);
    bus_wr(REG_CTRL, 32'(OP_READ_BIT));
    wait_idle();
    chk_len(oe_len, STD_RST_LOW_NS / 8);
    chk({31'h0, dev_od}, 32'h0);
    bus_rd(REG_STATUS, d);
    chk(d & 32'hf, 32'hc);
    bus_rd(REG_CTRL, d);
    chk(d, 32'h2);
    repeat (200) @(posedge clk_i);
    chk({31'h0, line_w}, 32'h1);
    chk_len(oe_len, STD_RST_LOW_NS / 8);
    stop_test();
  end
endmodule
`default_nettype wire
